/* design/rsr_recorder.sv */
// How it works
// - Each transition clears the order counter first
// - Sleep falling: busy set, phase 11
// - Sleep rising: busy set, phase 10
// - Active falling: busy set, phase 01
// - Overwrite enabled: replace log, flag if unread
// - Overwrite disabled, unread log: flag, keep old
// - Stamp overwrite enabled: replace, flag if unread
// - Stamp overwrite disabled, unread: flag, keep old
// - Each transition restarts the sequence timer
// - Sleep entry masks three classes per set
// - Exit and shutdown mask per their sets
// - Exit: unmask rail 5us after slow-UV rise
// - Falling: tag order at selected threshold, stamp
// - Rising exit: tag order at selected threshold, stamp
// - Store tags and stamps only when permitted
// - Mismatch against expected raises enabled interrupt
// - Blocked write skips compare and interrupt
// - Timeout stops tagging, clears busy
// - After entry: off masked rails watch OV only
// - Mismatch drives active-low interrupt, keeps running
// - Shutdown end: self-test if enabled, else idle
// - Active rising: busy set, phase 00
`timescale 1ns/10ps
`include "rsr_consts.svh"
module rsr_recorder #(
  parameter int N          = 6,
  parameter int TIMEOUT_US = `RSR_TIMEOUT_US
) (
  input  wire logic           mclk,
  input  wire logic           rst,
  input  wire logic           sleepIn,
  input  wire logic           powerOnRequestIn,
  input  wire logic [N-1:0]   railAboveUv,
  input  wire logic [N-1:0]   railAboveOff,
  input  wire logic           orderLogOverwriteEnable,
  input  wire logic           stampOverwriteEnable,
  input  wire logic [N-1:0]   sleepEntryAutomaskSet,
  input  wire logic [N-1:0]   sleepExitAutomaskSet,
  input  wire logic [N-1:0]   shutdownAutomaskSet,
  input  wire logic [N-1:0]   slowUnderIrqEnable,
  input  wire logic [N-1:0]   fastUnderIrqEnable,
  input  wire logic [N-1:0]   fastOverIrqEnable,
  input  wire logic [N-1:0]   riseThresholdSelect,
  input  wire logic [N-1:0]   fallThresholdSelect,
  input  wire logic [8*N-1:0] sleepEntryExpectedOrder,
  input  wire logic [8*N-1:0] sleepExitExpectedOrder,
  input  wire logic [8*N-1:0] shutdownExpectedOrder,
  input  wire logic           sleepEntrySeqIrqEnable,
  input  wire logic           sleepExitSeqIrqEnable,
  input  wire logic           shutdownSeqIrqEnable,
  input  wire logic           selftestOnShutdown,
  input  wire logic           selftestDone,
  input  wire logic           selftestPass,
  input  wire logic [2:0]     logReadAck,
  input  wire logic           stampReadAck,
  input  wire logic           faultIrqClear,
  output logic                recordingBusyFlag,
  output logic [1:0]          transitionPhaseCode,
  output logic [8*N-1:0]      sleepEntryOrderLog,
  output logic [8*N-1:0]      sleepExitOrderLog,
  output logic [8*N-1:0]      shutdownOrderLog,
  output logic [2:0]          logReady,
  output logic [2:0]          logOverrun,
  output logic                stampReadyFlag,
  output logic                stampOverrunFlag,
  output logic [8*N-1:0]      stampUpperByte,
  output logic [8*N-1:0]      stampLowerByte,
  output logic [N-1:0]        slowUnderIrqActive,
  output logic [N-1:0]        fastUnderIrqActive,
  output logic [N-1:0]        fastOverIrqActive,
  output logic [N-1:0]        slowOverOnly,
  output logic [1:0]          deviceState,
  output logic                selftestStart,
  output logic                faultIrqN
);
  localparam int TICK_CYC   = `RSR_TICK_CYC;
  localparam int UNMASK_CYC = `RSR_UNMASK_CYC;

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [2*N+1:0] pinSync;
  logic           sleepS, actS, sleepPrev_q, actPrev_q;
  logic [N-1:0]   uvS, offS;

  rsr_sync2 #(.W(2*N+2)) uSync (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn ({sleepIn, powerOnRequestIn, railAboveUv, railAboveOff}),
    .syncOut (pinSync)
  );
  assign {sleepS, actS, uvS, offS} = pinSync;

  // Previous levels reset low: a pin high at release reads as a rising edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      sleepPrev_q <= 1'b0;
      actPrev_q   <= 1'b0;
    end else begin
      sleepPrev_q <= sleepS;
      actPrev_q   <= actS;
    end
  end

  // Priority: shutdown over power-up over sleep edges
  logic       evt;
  logic [1:0] evtPhase, evtSlot;
  always_comb begin
    evt      = 1'b1;
    evtPhase = `RSR_PHASE_POWER_UP;
    evtSlot  = `RSR_SLOT_NONE;
    if (actPrev_q && !actS) begin
      evtPhase = `RSR_PHASE_SHUTDOWN;
      evtSlot  = `RSR_SLOT_SHUTDOWN;
    end else if (!actPrev_q && actS) begin
      evtPhase = `RSR_PHASE_POWER_UP;
    end else if (actS && sleepPrev_q && !sleepS) begin
      evtPhase = `RSR_PHASE_SLEEP_ENTRY;
      evtSlot  = `RSR_SLOT_ENTRY;
    end else if (actS && !sleepPrev_q && sleepS) begin
      evtPhase = `RSR_PHASE_SLEEP_EXIT;
      evtSlot  = `RSR_SLOT_EXIT;
    end else begin
      evt = 1'b0;
    end
  end

  // Rail has crossed the threshold its select bit chooses
  function automatic logic railCrossed(input logic rising, input logic sel,
                                       input logic aboveUv, input logic aboveOff);
    logic above;
    above = sel ? aboveOff : aboveUv;
    return rising ? above : !above;
  endfunction

  // ----------------------------------------------------------------
  // Recording state
  // ----------------------------------------------------------------
  rsr_pkg::rsr_state_e state_q, state_d;
  logic [1:0]          phase_q, phase_d, slot_q, slot_d;
  logic                busy_q, busy_d, seqWr_q, seqWr_d, stWr_q, stWr_d;
  logic [7:0]          count_q, count_d;
  logic [7:0]          tickCnt_q, tickCnt_d;
  logic [15:0]         timer_q, timer_d;
  logic [N-1:0]        tagged_q, tagged_d;
  logic [2:0]          ready_q, ready_d, over_q, over_d;
  logic                stRdy_q, stRdy_d, stOver_q, stOver_d, irq_q, irq_d, bist_q, bist_d;
  rsr_pkg::rsr_order_t log_q [3][N];
  rsr_pkg::rsr_order_t log_d [3][N];
  rsr_pkg::rsr_stamp_t stamp_q [N];
  rsr_pkg::rsr_stamp_t stamp_d [N];
  logic [N-1:0]        crossNow;
  rsr_pkg::rsr_order_t expOrd;
  logic                seqIen;

  // Transition start, tagging, timeout and end-of-record decision
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    slot_d = slot_q;
    busy_d = busy_q;
    seqWr_d = seqWr_q;
    stWr_d = stWr_q;
    count_d = count_q;
    tickCnt_d = tickCnt_q;
    timer_d = timer_q;
    tagged_d = tagged_q;
    ready_d = ready_q & ~logReadAck;
    over_d = over_q & ~logReadAck;
    stRdy_d = stRdy_q & ~stampReadAck;
    stOver_d = stOver_q & ~stampReadAck;
    irq_d = irq_q & ~faultIrqClear;
    bist_d = 1'b0;
    log_d = log_q;
    stamp_d = stamp_q;
    crossNow = '0;
    expOrd = 8'h00;
    seqIen = 1'b0;
    // Sequence timer ticks in microseconds, giving stamps and timeout
    if (busy_q) begin
      if (tickCnt_q == 8'(TICK_CYC - 1)) begin
        tickCnt_d = 8'h00;
        timer_d   = timer_q + 16'h0001;
      end else begin
        tickCnt_d = tickCnt_q + 8'h01;
      end
    end
    if (busy_q && slot_q != `RSR_SLOT_NONE) begin
      for (int i = 0; i < N; i++) begin
        crossNow[i] = !tagged_q[i] && railCrossed(slot_q == `RSR_SLOT_EXIT,
          slot_q == `RSR_SLOT_EXIT ? riseThresholdSelect[i] : fallThresholdSelect[i],
          uvS[i], offS[i]);
        if (crossNow[i]) begin
          tagged_d[i] = 1'b1;
          unique case (slot_q)
            `RSR_SLOT_ENTRY: begin
              expOrd = sleepEntryExpectedOrder[8*i +: 8];
              seqIen = sleepEntrySeqIrqEnable;
            end
            `RSR_SLOT_EXIT: begin
              expOrd = sleepExitExpectedOrder[8*i +: 8];
              seqIen = sleepExitSeqIrqEnable;
            end
            default: begin
              expOrd = shutdownExpectedOrder[8*i +: 8];
              seqIen = shutdownSeqIrqEnable;
            end
          endcase
          if (seqWr_q) begin
            log_d[slot_q][i] = count_q + 8'h01;
            ready_d[slot_q]  = 1'b1;
            if ((count_q + 8'h01) != expOrd) begin
              if (seqIen) begin
                irq_d = 1'b1;
              end
            end
          end
          if (stWr_q) begin
            stamp_d[i] = timer_q;
            stRdy_d    = 1'b1;
          end
        end
      end
      // Rails crossing together share one order value
      if (|crossNow) begin
        count_d = count_q + 8'h01;
      end
    end
    // Timeout ends tagging
    if (busy_q && timer_q == 16'(TIMEOUT_US)) begin
      busy_d = 1'b0;
      if (phase_q == `RSR_PHASE_SHUTDOWN) begin
        if (selftestOnShutdown) begin
          state_d = rsr_pkg::RSR_SELFTEST;
          bist_d  = 1'b1;
        end else begin
          state_d = rsr_pkg::RSR_IDLE;
        end
      end else begin
        state_d = rsr_pkg::RSR_ACTIVE;
      end
    end
    if (state_q == rsr_pkg::RSR_SELFTEST && selftestDone) begin
      state_d = selftestPass ? rsr_pkg::RSR_IDLE : rsr_pkg::RSR_ACTIVE;
    end
    // A new transition restarts counter, timer, tags and write permits; flags still set over acks
    if (evt) begin
      state_d   = rsr_pkg::RSR_RECORD;
      busy_d    = 1'b1;
      phase_d   = evtPhase;
      slot_d    = evtSlot;
      count_d   = `RSR_COUNT_RESET;
      tickCnt_d = 8'h00;
      timer_d   = 16'h0000;
      tagged_d  = '0;
      stWr_d    = stampOverwriteEnable || !stRdy_q;
      if (stRdy_q) begin
        stOver_d = 1'b1;
      end
      seqWr_d = 1'b0;
      if (evtSlot != `RSR_SLOT_NONE) begin
        seqWr_d = orderLogOverwriteEnable || !ready_q[evtSlot];
        if (ready_q[evtSlot]) begin
          over_d[evtSlot] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q   <= rsr_pkg::RSR_IDLE;
      phase_q   <= `RSR_PHASE_POWER_UP;
      slot_q    <= `RSR_SLOT_NONE;
      busy_q    <= 1'b0;
      seqWr_q   <= 1'b0;
      stWr_q    <= 1'b0;
      count_q   <= `RSR_COUNT_RESET;
      tickCnt_q <= 8'h00;
      timer_q   <= 16'h0000;
      tagged_q  <= '0;
      ready_q   <= 3'h0;
      over_q    <= 3'h0;
      stRdy_q   <= 1'b0;
      stOver_q  <= 1'b0;
      irq_q     <= 1'b0;
      bist_q    <= 1'b0;
      for (int i = 0; i < N; i++) begin
        stamp_q[i] <= 16'h0000;
        for (int s = 0; s < 3; s++) begin
          log_q[s][i] <= `RSR_LOG_RESET;
        end
      end
    end else begin
      state_q   <= state_d;
      phase_q   <= phase_d;
      slot_q    <= slot_d;
      busy_q    <= busy_d;
      seqWr_q   <= seqWr_d;
      stWr_q    <= stWr_d;
      count_q   <= count_d;
      tickCnt_q <= tickCnt_d;
      timer_q   <= timer_d;
      tagged_q  <= tagged_d;
      ready_q   <= ready_d;
      over_q    <= over_d;
      stRdy_q   <= stRdy_d;
      stOver_q  <= stOver_d;
      irq_q     <= irq_d;
      bist_q    <= bist_d;
      log_q     <= log_d;
      stamp_q   <= stamp_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt auto-masking and delayed unmask
  // ----------------------------------------------------------------
  logic [N-1:0] mask_q, mask_d;
  logic [9:0]   unmCnt_q [N];
  logic [9:0]   unmCnt_d [N];

  // Mask stays until, in the sleep-exit phase, the rail is seen above slow-UV long enough
  always_comb begin
    mask_d   = mask_q;
    unmCnt_d = unmCnt_q;
    if (evt) begin
      unique case (evtSlot)
        `RSR_SLOT_ENTRY:    mask_d = mask_q | sleepEntryAutomaskSet;
        `RSR_SLOT_EXIT:     mask_d = mask_q | sleepExitAutomaskSet;
        `RSR_SLOT_SHUTDOWN: mask_d = mask_q | shutdownAutomaskSet;
        default:            mask_d = mask_q;
      endcase
      for (int i = 0; i < N; i++) begin
        unmCnt_d[i] = 10'h000;
      end
    end else if (phase_q == `RSR_PHASE_SLEEP_EXIT) begin
      for (int i = 0; i < N; i++) begin
        if (mask_q[i] && uvS[i]) begin
          if (unmCnt_q[i] == 10'(UNMASK_CYC - 1)) begin
            mask_d[i] = 1'b0;
          end else begin
            unmCnt_d[i] = unmCnt_q[i] + 10'h001;
          end
        end else begin
          unmCnt_d[i] = 10'h000;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_q <= '0;
      for (int i = 0; i < N; i++) begin
        unmCnt_q[i] <= 10'h000;
      end
    end else begin
      mask_q   <= mask_d;
      unmCnt_q <= unmCnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Flatten the stores; all bits come straight from flip-flops
  always_comb begin
    for (int i = 0; i < N; i++) begin
      sleepEntryOrderLog[8*i +: 8] = log_q[`RSR_SLOT_ENTRY][i];
      sleepExitOrderLog[8*i +: 8]  = log_q[`RSR_SLOT_EXIT][i];
      shutdownOrderLog[8*i +: 8]   = log_q[`RSR_SLOT_SHUTDOWN][i];
      stampUpperByte[8*i +: 8]     = stamp_q[i][15:8];
      stampLowerByte[8*i +: 8]     = stamp_q[i][7:0];
    end
  end

  // Masked rails follow their own enables once unmasked
  assign slowUnderIrqActive  = slowUnderIrqEnable & ~mask_q;
  assign fastUnderIrqActive  = fastUnderIrqEnable & ~mask_q;
  assign fastOverIrqActive   = fastOverIrqEnable & ~mask_q;
  assign slowOverOnly        = mask_q & ~offS;
  assign recordingBusyFlag   = busy_q;
  assign transitionPhaseCode = phase_q;
  assign logReady            = ready_q;
  assign logOverrun          = over_q;
  assign stampReadyFlag      = stRdy_q;
  assign stampOverrunFlag    = stOver_q;
  assign deviceState         = state_q;
  assign selftestStart       = bist_q;
  assign faultIrqN           = !irq_q;
endmodule // rsr_recorder

/* design/rsr_consts.svh */
`ifndef RSR_CONSTS_SVH
`define RSR_CONSTS_SVH

// ----------------------------------------------------------------
// Transition phase codes
// ----------------------------------------------------------------
`define RSR_PHASE_POWER_UP    2'h0
`define RSR_PHASE_SHUTDOWN    2'h1
`define RSR_PHASE_SLEEP_EXIT  2'h2
`define RSR_PHASE_SLEEP_ENTRY 2'h3

// ----------------------------------------------------------------
// Log slots and reset values
// ----------------------------------------------------------------
`define RSR_SLOT_ENTRY    2'h0
`define RSR_SLOT_EXIT     2'h1
`define RSR_SLOT_SHUTDOWN 2'h2
`define RSR_SLOT_NONE     2'h3
`define RSR_COUNT_RESET   8'h00
`define RSR_LOG_RESET     8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RSR_CLK_PERIOD_NS 5
`define RSR_TICK_NS       1000
`define RSR_TICK_CYC      (`RSR_TICK_NS / `RSR_CLK_PERIOD_NS)
`define RSR_UNMASK_NS     5000
`define RSR_UNMASK_CYC    ((`RSR_UNMASK_NS + `RSR_CLK_PERIOD_NS - 1) / `RSR_CLK_PERIOD_NS)
`define RSR_TIMEOUT_US    10000

`endif

/* design/rsr_pkg.sv */
package rsr_pkg;
  typedef enum logic [1:0] {
    RSR_IDLE     = 2'b00,
    RSR_ACTIVE   = 2'b01,
    RSR_RECORD   = 2'b10,
    RSR_SELFTEST = 2'b11
  } rsr_state_e;

  typedef logic [7:0]  rsr_order_t;
  typedef logic [15:0] rsr_stamp_t;
endpackage

/* design/rsr_sync2.sv */
`timescale 1ns/10ps
// Two-stage synchroniser for pin inputs
module rsr_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_q;

  // Only the second stage is ever read
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // rsr_sync2

/* tb/rsr_recorder_asserts.sv */
`timescale 1ns/10ps
`include "rsr_consts.svh"
// ----------------------------------------------------------------
// Port-level checks of the rail sequence recorder
// ----------------------------------------------------------------
module rsr_recorder_asserts #(
  parameter int N          = 6,
  parameter int TIMEOUT_US = `RSR_TIMEOUT_US
) (
  input wire logic           mclk,
  input wire logic           rst,
  input wire logic           sleepIn,
  input wire logic           powerOnRequestIn,
  input wire logic           orderLogOverwriteEnable,
  input wire logic           stampOverwriteEnable,
  input wire logic [N-1:0]   sleepEntryAutomaskSet,
  input wire logic           sleepEntrySeqIrqEnable,
  input wire logic           sleepExitSeqIrqEnable,
  input wire logic           shutdownSeqIrqEnable,
  input wire logic           selftestOnShutdown,
  input wire logic           selftestDone,
  input wire logic           selftestPass,
  input wire logic           recordingBusyFlag,
  input wire logic [1:0]     transitionPhaseCode,
  input wire logic [8*N-1:0] sleepEntryOrderLog,
  input wire logic [2:0]     logOverrun,
  input wire logic           stampOverrunFlag,
  input wire logic [8*N-1:0] stampLowerByte,
  input wire logic [N-1:0]   slowUnderIrqActive,
  input wire logic [N-1:0]   fastUnderIrqActive,
  input wire logic [N-1:0]   fastOverIrqActive,
  input wire logic [1:0]     deviceState,
  input wire logic           selftestStart,
  input wire logic           faultIrqN
);
  localparam int LIM = TIMEOUT_US * `RSR_TICK_CYC;
  int busyCntD;
  int busyCntQ;

  // Length of the running recording window; a restart would stretch it
  always_comb begin
    busyCntD = recordingBusyFlag ? busyCntQ + 1 : 0;
  end
  always_ff @(posedge mclk) begin
    busyCntQ <= rst ? 0 : busyCntD;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_sleep_fall;
    $fell(sleepIn) && powerOnRequestIn;
  endsequence
  sequence s_sleep_rise;
    $rose(sleepIn) && powerOnRequestIn;
  endsequence
  sequence s_shutdown_end;
    $fell(recordingBusyFlag) && transitionPhaseCode == `RSR_PHASE_SHUTDOWN;
  endsequence

  a_entry_phase: assert property (s_sleep_fall |-> ##4 recordingBusyFlag &&
    transitionPhaseCode == `RSR_PHASE_SLEEP_ENTRY) else $error("sleep entry not started");
  a_exit_phase: assert property (s_sleep_rise |-> ##4 recordingBusyFlag &&
    transitionPhaseCode == `RSR_PHASE_SLEEP_EXIT) else $error("sleep exit not started");
  a_shutdown_phase: assert property ($fell(powerOnRequestIn) |-> ##4 recordingBusyFlag &&
    transitionPhaseCode == `RSR_PHASE_SHUTDOWN) else $error("shutdown not started");
  a_powerup_phase: assert property ($rose(powerOnRequestIn) |-> ##4 recordingBusyFlag &&
    transitionPhaseCode == `RSR_PHASE_POWER_UP) else $error("power-up not started");
  a_busy_window: assert property ($fell(recordingBusyFlag) |->
    busyCntQ >= LIM - 4 && busyCntQ <= LIM + 4) else $error("recording window length wrong");
  a_entry_automask: assert property (s_sleep_fall |-> ##5
    ((slowUnderIrqActive | fastUnderIrqActive | fastOverIrqActive) & sleepEntryAutomaskSet) == '0)
    else $error("entry automask not applied");
  a_irq_quiet: assert property (faultIrqN && !(sleepEntrySeqIrqEnable ||
    sleepExitSeqIrqEnable || shutdownSeqIrqEnable) |=> faultIrqN) else $error("irq while disabled");
  a_entry_log_kept: assert property (recordingBusyFlag && logOverrun[0] &&
    transitionPhaseCode == `RSR_PHASE_SLEEP_ENTRY && !orderLogOverwriteEnable
    |=> $stable(sleepEntryOrderLog)) else $error("blocked entry log changed");
  a_stamp_kept: assert property (recordingBusyFlag && stampOverrunFlag &&
    !stampOverwriteEnable |=> $stable(stampLowerByte)) else $error("blocked stamp changed");
  a_selftest_start: assert property (s_shutdown_end ##0 selftestOnShutdown
    |-> ##[0:3] selftestStart) else $error("self-test not started");
  a_selftest_pass: assert property (selftestDone && selftestPass &&
    deviceState == rsr_pkg::RSR_SELFTEST |-> ##[1:3] deviceState == rsr_pkg::RSR_IDLE)
    else $error("passed self-test not idle");
endmodule // rsr_recorder_asserts

bind rsr_recorder rsr_recorder_asserts #(.N(N), .TIMEOUT_US(TIMEOUT_US)) asrt (.*);

/* tb/rsr_rail_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Supply rails driven by the sequencer
// ----------------------------------------------------------------
module rsr_rail_model #(
  parameter int N = 4
) (
  input  wire logic         mclk,
  input  wire logic [N-1:0] railCmd,
  output logic      [N-1:0] railAboveUv,
  output logic      [N-1:0] railAboveOff
);
  // Rails start discharged
  initial begin
    railAboveUv = '0;
    railAboveOff = '0;
  end
  // Off level leads on a ramp up and trails on a ramp down, as real supplies do
  always @(posedge mclk) begin
    railAboveUv <= #1 railCmd & railAboveOff;
    railAboveOff <= #1 railCmd | railAboveUv;
  end
endmodule // rsr_rail_model

/* tb/rsr_recorder_tb.sv */
`timescale 1ns/10ps
`include "rsr_consts.svh"
module rsr_recorder_tb;
  localparam int N   = 4;
  localparam int TUS = 10;
  logic           mclk = 1'b0, rst = 1'b1, sleepIn = 1'b1, powerOnRequestIn = 1'b0;
  logic           orderLogOverwriteEnable = 1'b0, stampOverwriteEnable = 1'b0;
  logic           sleepEntrySeqIrqEnable = 1'b0, sleepExitSeqIrqEnable = 1'b0;
  logic           shutdownSeqIrqEnable = 1'b0, selftestOnShutdown = 1'b1;
  logic           selftestDone = 1'b0, selftestPass = 1'b0;
  logic           stampReadAck = 1'b0, faultIrqClear = 1'b0;
  logic [2:0]     logReadAck = 3'h0;
  logic [N-1:0]   railCmd = '0, sleepEntryAutomaskSet = '0, sleepExitAutomaskSet = '0;
  logic [N-1:0]   shutdownAutomaskSet = '0, slowUnderIrqEnable = '0, fastUnderIrqEnable = '0;
  logic [N-1:0]   fastOverIrqEnable = '0, riseThresholdSelect = '0, fallThresholdSelect = '0;
  logic [8*N-1:0] sleepEntryExpectedOrder = '0, sleepExitExpectedOrder = '0;
  logic [8*N-1:0] shutdownExpectedOrder = '0;
  logic           recordingBusyFlag, stampReadyFlag, stampOverrunFlag, selftestStart, faultIrqN;
  logic [1:0]     transitionPhaseCode, deviceState;
  logic [2:0]     logReady, logOverrun;
  logic [N-1:0]   railAboveUv, railAboveOff, slowUnderIrqActive, fastUnderIrqActive;
  logic [N-1:0]   fastOverIrqActive, slowOverOnly;
  logic [8*N-1:0] sleepEntryOrderLog, sleepExitOrderLog, shutdownOrderLog;
  logic [8*N-1:0] stampUpperByte, stampLowerByte;
  logic [8*N-1:0] expLog [3] = '{'0, '0, '0};
  logic [8*N-1:0] expStamp = '0;
  logic [2:0]     expRdy = 3'h0, expOvr = 3'h0;
  logic [N-1:0]   expMask = '0;
  logic           expTsRdy = 1'b0, expTsOvr = 1'b0;
  logic [31:0]    rnd = 32'hDA4D2373;
  int             miscompares = 0, checkCount = 0;

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  rsr_rail_model #(.N(N)) rails (.mclk, .railCmd, .railAboveUv, .railAboveOff);
  rsr_recorder #(.N(N), .TIMEOUT_US(TUS)) uut (.*);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Byte per rail: its position in the crossing order plus an offset
  function automatic logic [8*N-1:0] orderBytes(input int ord [4], input int base);
    logic [8*N-1:0] v;
    v = '0;
    for (int i = 0; i < N; i++) v[8*ord[i]+:8] = 8'(i + base);
    return v;
  endfunction
  function automatic logic [8*N-1:0] logOf(input int s);
    return s == 0 ? sleepEntryOrderLog : s == 1 ? sleepExitOrderLog : shutdownOrderLog;
  endfunction
  task automatic chk(input logic [8*N-1:0] got, input logic [8*N-1:0] exp);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Bounded wait on the recording flag; a hang ends the run
  task automatic waitBusy(input logic lvl);
    for (int i = 0; i < 4000 && recordingBusyFlag !== lvl; i++) tick(1);
    if (recordingBusyFlag !== lvl) begin
      miscompares++;
      finalReport();
    end
  endtask

  // ----------------------------------------------------------------
  // One recorded transition: 0 entry, 1 exit, 2 shutdown
  // ----------------------------------------------------------------
  task automatic runTx(input int k, input logic ow, tsow, bad, ack);
    int             ord [4] = '{0, 1, 2, 3};
    int             j, t;
    logic [8*N-1:0] tag, stamp, eOrd;
    logic [N-1:0]   aset;
    logic [8:0]     st;
    logic           wr, irq;
    if (ack) begin
      logReadAck = 3'h7;
      stampReadAck = 1'b1;
      tick(1);
      logReadAck = 3'h0;
      stampReadAck = 1'b0;
      {expRdy, expOvr, expTsRdy, expTsOvr} = '0;
    end
    for (int i = N - 1; i > 0; i--) begin
      rnd = lfsr(rnd);
      j = int'(rnd % (i + 1));
      t = ord[i];
      ord[i] = ord[j];
      ord[j] = t;
    end
    rnd = lfsr(rnd);
    {sleepEntryAutomaskSet, sleepExitAutomaskSet, shutdownAutomaskSet} = rnd[3*N-1:0];
    {riseThresholdSelect, fallThresholdSelect} = rnd[5*N-1:3*N];
    {shutdownSeqIrqEnable, sleepExitSeqIrqEnable, sleepEntrySeqIrqEnable} = rnd[22:20] | {3{bad}};
    rnd = lfsr(rnd);
    {slowUnderIrqEnable, fastUnderIrqEnable, fastOverIrqEnable} = rnd[3*N-1:0];
    aset = k == 0 ? sleepEntryAutomaskSet : k == 1 ? sleepExitAutomaskSet : shutdownAutomaskSet;
    tag = orderBytes(ord, 1);
    stamp = orderBytes(ord, 0);
    eOrd = tag;
    if (bad) eOrd[8*ord[0]+:8] = 8'h07;
    {sleepEntryExpectedOrder, sleepExitExpectedOrder, shutdownExpectedOrder} = {3{eOrd}};
    orderLogOverwriteEnable = ow;
    stampOverwriteEnable = tsow;
    // Expected outcome of the overwrite policy, decided once per transition
    wr = ow || !expRdy[k];
    irq = wr && bad;
    expOvr[k] = expOvr[k] | expRdy[k];
    expTsOvr = expTsOvr | expTsRdy;
    if (wr) expLog[k] = tag;
    if (tsow || !expTsRdy) expStamp = stamp;
    expRdy[k] = 1'b1;
    expTsRdy = 1'b1;
    expMask = expMask | aset;
    if (k == 2) powerOnRequestIn = 1'b0;
    else sleepIn = (k == 1);
    waitBusy(1'b1);
    chk(32'(transitionPhaseCode), 32'(k == 0 ? `RSR_PHASE_SLEEP_ENTRY : k == 1 ?
      `RSR_PHASE_SLEEP_EXIT : `RSR_PHASE_SHUTDOWN));
    chk(32'((slowUnderIrqActive | fastUnderIrqActive | fastOverIrqActive) & aset), '0);
    // Rails cross 200 cycles apart, so each lands in its own microsecond
    tick(96);
    for (int i = 0; i < N; i++) begin
      railCmd[ord[i]] = (k == 1);
      tick(200);
    end
    waitBusy(1'b0);
    chk(logOf(k), expLog[k]);
    chk(stampLowerByte, expStamp);
    chk(stampUpperByte, '0);
    st = {logReady, logOverrun, stampReadyFlag, stampOverrunFlag, faultIrqN};
    chk(32'(st), 32'({expRdy, expOvr, expTsRdy, expTsOvr, !irq}));
    faultIrqClear = 1'b1;
    tick(1);
    faultIrqClear = 1'b0;
    if (k == 1) begin
      expMask = '0;
      chk(32'(slowUnderIrqActive), 32'(slowUnderIrqEnable));
    end
    if (k == 0) chk(32'(slowOverOnly), 32'(expMask));
    if (k < 2) chk(32'(deviceState), 32'(rsr_pkg::RSR_ACTIVE));
    else begin
      tick(3);
      chk(32'(deviceState), 32'(rsr_pkg::RSR_SELFTEST));
      selftestDone = 1'b1;
      selftestPass = rnd[23];
      tick(1);
      selftestDone = 1'b0;
      tick(2);
      chk(32'(deviceState), 32'(rnd[23] ? rsr_pkg::RSR_IDLE : rsr_pkg::RSR_ACTIVE));
    end
    $display("transition %0d done, mismatches so far %0d", k, miscompares);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(2);
    rst = 1'b0;
    chk(32'({recordingBusyFlag, faultIrqN, deviceState}), 32'h4);
    powerOnRequestIn = 1'b1;
    waitBusy(1'b1);
    chk(32'(transitionPhaseCode), 32'(`RSR_PHASE_POWER_UP));
    railCmd = '1;
    waitBusy(1'b0);
    chk(32'({logReady, deviceState}), 32'({3'h0, rsr_pkg::RSR_ACTIVE}));
    $display("power-up done, mismatches so far %0d", miscompares);
    runTx(0, 1'b0, 1'b0, 1'b1, 1'b0);
    runTx(1, 1'b0, 1'b0, 1'b0, 1'b0);
    runTx(0, 1'b0, 1'b0, 1'b1, 1'b0);
    runTx(1, 1'b1, 1'b1, 1'b1, 1'b0);
    runTx(2, 1'b0, 1'b1, 1'b1, 1'b1);
    finalReport();
  end
endmodule // rsr_recorder_tb
